// ### hw/sfrp_defs.vh
// Register offsets, field positions and reset values of the FIFO read port.
`ifndef SFRP_DEFS_VH
`define SFRP_DEFS_VH
`define SFRP_OFS_STATUS 8'h00
`define SFRP_OFS_AE_OFFSET 8'h04
`define SFRP_OFS_AF_OFFSET 8'h08
`define SFRP_OFS_IRQ_STATUS 8'h0C
`define SFRP_OFS_IRQ_MASK 8'h10
`define SFRP_AE_OFFSET_RST 13'h0007
`define SFRP_AF_OFFSET_RST 13'h0007
`define SFRP_IRQ_MASK_RST 6'h00
`define SFRP_IRQ_EMPTY 0
`define SFRP_IRQ_ALMOST_EMPTY 1
`define SFRP_IRQ_ALMOST_FULL 2
`define SFRP_IRQ_FULL 3
`define SFRP_IRQ_OVERFLOW 4
`define SFRP_IRQ_UNDERFLOW 5
`define SFRP_IRQ_BITS 6
`define SFRP_ST_EMPTY_N 0
`define SFRP_ST_ALMOST_EMPTY_N 1
`define SFRP_ST_ALMOST_FULL_N 2
`define SFRP_ST_FULL_N 3
`define SFRP_ST_DUAL_ENABLE 4
`define SFRP_ST_COUNT_LSB 16
`endif

// ### hw/sfrp_fifo.v
// Synchronous 9-bit FIFO with read port, status flags and register slave.
`timescale 1ns/10ps
`include "sfrp_defs.vh"

module sfrp_fifo #(
  parameter DATA_W = 9,
  parameter ADDR_W = 6,
  parameter DEPTH = 64
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_b,
  // Write port.
  input wire [DATA_W-1:0] write_data_in,
  input wire write_enable_a_n,
  input wire write_enable_b_or_offset_load,
  // Read port.
  input wire read_enable_a_n,
  input wire read_enable_b_n,
  input wire output_enable_n,
  output reg [DATA_W-1:0] read_data_out,
  output reg read_data_oe,
  // Flags.
  output reg empty_flag_n,
  output reg almost_empty_flag_n,
  output reg almost_full_flag_n,
  output reg full_flag_n,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Interrupt.
  output reg irq
);

  // The occupancy counter is one bit wider than the pointers.
  // Full and empty then have distinct codes and need no extra state.
  // The pointers wrap on their own, so DEPTH must be a power of two.
  // A depth that is not a power of two would need explicit wrap logic.
  localparam CNT_W = ADDR_W + 1;
  // Depth as a counter-wide constant, for the full and free-space terms.
  localparam [CNT_W-1:0] DEPTH_C = DEPTH[CNT_W-1:0];

  // Storage and pointer state.
  // The array has no reset because its contents only matter once written.
  // The read pointer always names the oldest unread word.
  // The write pointer always names the next free location.

  reg [DATA_W-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_reg;
  reg [ADDR_W-1:0] rd_ptr_reg;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;
  // Mode strap, caught while reset is held.
  reg dual_enable_reg;
  // Programmable thresholds and interrupt state.
  // The offsets are 13 bits wide so that deeper builds need no new layout.
  reg [12:0] ae_offset_reg;
  reg [12:0] af_offset_reg;
  reg [`SFRP_IRQ_BITS-1:0] irq_status_reg;
  reg [`SFRP_IRQ_BITS-1:0] irq_mask_reg;
  reg [`SFRP_IRQ_BITS-1:0] irq_status_next;
  reg [`SFRP_IRQ_BITS-1:0] irq_event;
  // Combinational read value for the bus, registered on the taking edge.
  reg [31:0] rd_mux;
  // Decoded requests and next flag levels.
  wire [CNT_W-1:0] free_next;
  wire write_req;
  wire read_req;
  wire write_go;
  wire read_go;
  wire bus_req;
  wire bus_wr;
  wire ofs_write_ok;
  wire ae_next_n;
  wire af_next_n;
  wire empty_next_n;
  wire full_next_n;

  // Write request decoded from the enables in the selected mode.
  assign write_req = ~write_enable_a_n &
    (~dual_enable_reg | write_enable_b_or_offset_load);
  // Full blocks the store so no unread word is overwritten.
  assign write_go = write_req & full_flag_n;
  // Both read enables must be low for a read request.
  assign read_req = ~read_enable_a_n & ~read_enable_b_n;
  // Empty suppresses the read, keeping the pointer in place.
  assign read_go = read_req & empty_flag_n;

  // Occupancy after this edge; flags are derived from it so they are
  // exact in the same cycle the pointers move.
  // A simultaneous store and fetch leaves the count unchanged.
  // When full, a fetch frees a slot but the same-edge store is still
  // refused, because the full flag seen at this edge blocks it.
  // When empty, a store lands but the same-edge fetch is refused, so a
  // word is never delivered in the cycle it is written.
  // The cost is one cycle of latency at either end of the range.
  always @* begin
    count_next = count_reg;
    if (write_go & ~read_go) begin
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (read_go & ~write_go) begin
      count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Free space after this edge, used by the almost-full threshold.
  // The subtraction cannot underflow because the count never passes DEPTH.
  assign free_next = DEPTH_C - count_next;
  // Flag levels for the next cycle, all active low.
  // Empty and full test exact codes; the almost flags are inclusive.
  assign empty_next_n = (count_next != {CNT_W{1'b0}});
  assign full_next_n = (count_next != DEPTH_C);
  // Offsets wider than the counter compare against a zero-extended count.
  assign ae_next_n = ({{(13-CNT_W){1'b0}}, count_next} >
    ae_offset_reg);
  assign af_next_n = ({{(13-CNT_W){1'b0}}, free_next} >
    af_offset_reg);

  // Storage array, written without reset since contents are don't-care.
  always @(posedge core_clk) begin
    if (write_go) begin
      mem[wr_ptr_reg] <= write_data_in;
    end
  end

  // Pointers, count, flags and the registered read data.
  // All four flags are registered so every output leaves a flip-flop.
  // The read word stays on the outputs until the next accepted read.
  // The output enable is registered as well; the outer pad ring turns
  // read_data_oe into the actual three-state control of the bus.
  // A refused read leaves both the pointer and the output word alone.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= {ADDR_W{1'b0}};
      rd_ptr_reg <= {ADDR_W{1'b0}};
      count_reg <= {CNT_W{1'b0}};
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
      full_flag_n <= 1'b1;
      read_data_out <= {DATA_W{1'b0}};
      read_data_oe <= 1'b0;
    end else begin
      if (write_go) begin
        wr_ptr_reg <= wr_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
      if (read_go) begin
        rd_ptr_reg <= rd_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
        read_data_out <= mem[rd_ptr_reg];
      end
      count_reg <= count_next;
      empty_flag_n <= empty_next_n;
      almost_empty_flag_n <= ae_next_n;
      almost_full_flag_n <= af_next_n;
      full_flag_n <= full_next_n;
      read_data_oe <= ~output_enable_n;
    end
  end

  // The shared pin is caught while reset is held; the last value before
  // release decides the mode for the whole session.
  // Changing the pin afterwards does not change the mode; a new reset
  // is needed for that.
  // The strap has no reset value of its own, since reset is its load.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      dual_enable_reg <= write_enable_b_or_offset_load;
    end
  end

  // Bus decode; a single-cycle answer keeps the slave simple.
  // The ack term in the request stops a held strobe being taken twice.
  // The master need not drop the strobe between transfers; the ack cycle leaves the gap.
  // Every address is acknowledged, mapped or not, so a stray access
  // never hangs the bus.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  // In offset mode the pin must be held low to alter the offsets.
  assign ofs_write_ok = dual_enable_reg |
    ~write_enable_b_or_offset_load;

  // Flag edges become interrupt events.
  // Only the moment a flag becomes active raises an event, so a level
  // that persists does not refill a status bit just cleared.
  // Refused stores and fetches raise events on every refused edge.
  always @* begin
    irq_event = {`SFRP_IRQ_BITS{1'b0}};
    irq_event[`SFRP_IRQ_EMPTY] = ~empty_next_n & empty_flag_n;
    irq_event[`SFRP_IRQ_ALMOST_EMPTY] = ~ae_next_n & almost_empty_flag_n;
    irq_event[`SFRP_IRQ_ALMOST_FULL] = ~af_next_n & almost_full_flag_n;
    irq_event[`SFRP_IRQ_FULL] = ~full_next_n & full_flag_n;
    irq_event[`SFRP_IRQ_OVERFLOW] = write_req & ~full_flag_n;
    irq_event[`SFRP_IRQ_UNDERFLOW] = read_req & ~empty_flag_n;
  end

  // Write-one-to-clear; a new event in the same cycle wins over the clear.
  always @* begin
    irq_status_next = irq_status_reg;
    if (bus_wr && wb_adr_i == `SFRP_OFS_IRQ_STATUS && wb_sel_i[0]) begin
      irq_status_next = irq_status_reg & ~wb_dat_i[`SFRP_IRQ_BITS-1:0];
    end
    irq_status_next = irq_status_next | irq_event;
  end

  // Read data multiplexer; unmapped addresses read as zero.
  // The status word shows the flags as registered, not their next values.
  // The count field lets software size a burst without a second access.
  always @* begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `SFRP_OFS_STATUS: begin
        rd_mux[`SFRP_ST_EMPTY_N] = empty_flag_n;
        rd_mux[`SFRP_ST_ALMOST_EMPTY_N] = almost_empty_flag_n;
        rd_mux[`SFRP_ST_ALMOST_FULL_N] = almost_full_flag_n;
        rd_mux[`SFRP_ST_FULL_N] = full_flag_n;
        rd_mux[`SFRP_ST_DUAL_ENABLE] = dual_enable_reg;
        rd_mux[`SFRP_ST_COUNT_LSB +: CNT_W] = count_reg;
      end
      `SFRP_OFS_AE_OFFSET: rd_mux[12:0] = ae_offset_reg;
      `SFRP_OFS_AF_OFFSET: rd_mux[12:0] = af_offset_reg;
      `SFRP_OFS_IRQ_STATUS: rd_mux[`SFRP_IRQ_BITS-1:0] = irq_status_reg;
      `SFRP_OFS_IRQ_MASK: rd_mux[`SFRP_IRQ_BITS-1:0] = irq_mask_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Registers, bus answer and interrupt output.
  // Offset writes take effect on the edge that takes the request; the
  // ack that follows only reports the transfer as done.
  // In offset mode the shared pin must be low for offset writes to land.
  // The interrupt is computed from the next status so that it rises on
  // the same edge as the status bit behind it.
  // Mask writes take effect one edge later than the status they gate.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      ae_offset_reg <= `SFRP_AE_OFFSET_RST;
      af_offset_reg <= `SFRP_AF_OFFSET_RST;
      irq_status_reg <= {`SFRP_IRQ_BITS{1'b0}};
      irq_mask_reg <= `SFRP_IRQ_MASK_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_mux;
      end
      if (bus_wr && ofs_write_ok && wb_adr_i == `SFRP_OFS_AE_OFFSET) begin
        if (wb_sel_i[0]) begin
          ae_offset_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ae_offset_reg[12:8] <= wb_dat_i[12:8];
        end
      end
      if (bus_wr && ofs_write_ok && wb_adr_i == `SFRP_OFS_AF_OFFSET) begin
        if (wb_sel_i[0]) begin
          af_offset_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          af_offset_reg[12:8] <= wb_dat_i[12:8];
        end
      end
      if (bus_wr && wb_adr_i == `SFRP_OFS_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_reg <= wb_dat_i[`SFRP_IRQ_BITS-1:0];
      end
      irq_status_reg <= irq_status_next;
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule

// ### verif/sfrp_fifo_assertions.sv
// Checker for the FIFO read port and flags, bound to the FIFO module.
`timescale 1ns/10ps
module sfrp_fifo_chk (
  // Clock and reset.
  input wire core_clk,
  input wire rst_b,
  // Enables and read port.
  input wire write_enable_a_n,
  input wire write_enable_b_or_offset_load,
  input wire read_enable_a_n,
  input wire read_enable_b_n,
  input wire output_enable_n,
  input wire [8:0] read_data_out,
  input wire read_data_oe,
  // Flags.
  input wire empty_flag_n,
  input wire almost_empty_flag_n,
  input wire almost_full_flag_n,
  input wire full_flag_n
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire rd = !read_enable_a_n && !read_enable_b_n;
  a_empty_no_read: assert property (!empty_flag_n && rd |=>
    $stable(read_data_out)) else $error("read taken while empty");
  a_oe_off: assert property (output_enable_n |=> !read_data_oe)
    else $error("bus driven while disabled");
  a_empty_stays: assert property (!empty_flag_n && write_enable_a_n
    |=> !empty_flag_n) else $error("empty left without write");
  a_write_fills: assert property (!empty_flag_n && !write_enable_a_n
    && write_enable_b_or_offset_load |=> empty_flag_n) else $error("lost");
  a_full_stays: assert property (!full_flag_n && !rd |=> !full_flag_n)
    else $error("full left without read");
  a_ae_at_empty: assert property (
    !empty_flag_n |-> !almost_empty_flag_n) else $error("ae high");
  a_af_at_full: assert property (
    !full_flag_n |-> !almost_full_flag_n) else $error("af high");
  a_reset_flags: assert property (disable iff (1'b0) !rst_b |=>
    !empty_flag_n && !almost_empty_flag_n && full_flag_n && almost_full_flag_n)
    else $error("flags wrong in reset");
endmodule
bind sfrp_fifo sfrp_fifo_chk u_chk (.*);

// ### verif/sfrp_fifo_tb_top.sv
// Bench: strap modes, fill with flag steps, refusals, drain, interrupts.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sfrp_fifo_tb_top;
  reg core_clk = 1'b0, rst_b = 1'b0, we_n = 1'b1, pin = 1'b0, oe_n = 1'b0;
  reg cyc = 1'b0, we = 1'b0, drain = 1'b0, slow = 1'b1, take = 1'b0;
  reg oe_d = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [8:0] wd = 9'h000, rx;
  reg [31:0] dat = 32'h00000000, rdat;
  reg [8:0] fq[$];
  reg [31:0] wq[$];
  wire ren_a, ren_b, oe, ef, ff, ack, irq, ae, af;
  wire [8:0] rdo;
  wire [31:0] dato;
  integer seed = 18946, fails = 0, compares = 0, i, n, t;
  sfrp_fifo uut (.core_clk(core_clk), .rst_b(rst_b), .write_data_in(wd),
    .write_enable_a_n(we_n), .write_enable_b_or_offset_load(pin),
    .read_enable_a_n(ren_a), .read_enable_b_n(ren_b),
    .output_enable_n(oe_n), .read_data_out(rdo), .read_data_oe(oe),
    .empty_flag_n(ef), .almost_empty_flag_n(ae), .almost_full_flag_n(af),
    .full_flag_n(ff), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dato),
    .wb_ack_o(ack), .irq(irq));
  sfrp_reader rdr (.core_clk(core_clk), .drain(drain), .slow(slow),
    .read_enable_a_n(ren_a), .read_enable_b_n(ren_b));
  // Free-running 200 MHz clock.
  always #2.5 core_clk = !core_clk;
  // Notes reads the FIFO took; bus replies are checked at their ack edge.
  always @(posedge core_clk) begin
    take <= rst_b && !ren_a && !ren_b && ef;
    oe_d <= !oe_n;
    oe_n <= $random(seed) % 2 != 0;
    if (ack && !we) begin
      rdat = wq.pop_front();
      `CHK(dato, rdat)
    end
  end
  // Read data is looked at half a cycle after the edge that took it.
  always @(negedge core_clk) if (take) begin
    rx = fq.pop_front();
    `CHK(rdo, rx)
    `CHK(oe, oe_d)
  end
  // Status word expected for a fill level c with default offsets.
  function [31:0] st(input [6:0] c, input m);
    st = {9'h000, c, 11'h000, m, c != 64, 64 - c > 7, c > 7, c != 0};
  endfunction
  task tally_and_finish;
    begin
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Classic bus cycle; the request holds until ack is sampled.
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      for (t = 0; t < 50 && ack !== 1'b1; t++) @(posedge core_clk);
      cyc <= 1'b0;
      if (t == 50) begin fails++; tally_and_finish; end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin wq.push_back(e); wb(1'b0, a, 32'h00000000); end
  endtask
  task push(input [8:0] d, input ok);
    begin
      @(posedge core_clk);
      we_n <= 1'b0;
      wd <= d;
      if (ok) fq.push_back(d);
      @(posedge core_clk);
      we_n <= 1'b1;
    end
  endtask
  // Dual-enable strap refuses a write with the second enable low.
  initial begin
    for (i = 1; i >= 0; i--) begin
      rst_b <= 1'b0;
      pin <= i[0];
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      pin <= 1'b0;
      push(9'h1FF, !i[0]);
      rd(8'h00, st({6'h00, !i[0]}, i[0]));
    end
    rd(8'h04, 32'h00000007);
    rd(8'h08, 32'h00000007);
    rd(8'h14, 32'h00000000);
    wb(1'b1, 8'h10, 32'h00000010);
    for (n = 2; n <= 64; n++) begin
      push(9'($random(seed)), 1'b1);
      rd(8'h00, st(7'(n), 1'b0));
      `CHK({ff, af, ae}, {n != 64, 64 - n > 7, n > 7})
    end
    `CHK(irq, 1'b0)
    push(9'h0AA, 1'b0);
    rd(8'h00, st(7'h40, 1'b0));
    `CHK(irq, 1'b1)
    wb(1'b1, 8'h0C, 32'h00000010);
    `CHK(irq, 1'b0)
    drain <= 1'b1;
    for (t = 0; t < 2000 && ef !== 1'b0; t++) @(posedge core_clk);
    `CHK(ef, 1'b0)
    repeat (4) @(posedge core_clk);
    drain <= 1'b0;
    `CHK(fq.size(), 0)
    wb(1'b1, 8'h10, 32'h00000020);
    rd(8'h00, st(7'h00, 1'b0));
    `CHK(irq, 1'b1)
    tally_and_finish;
  end
endmodule

// ### verif/sfrp_reader.sv
// Reading system model that drains the FIFO promptly or with stalls.
`timescale 1ns/10ps
module sfrp_reader (
  // Clock and control from the bench.
  input wire core_clk,
  input wire drain,
  input wire slow,
  // Read enables toward the FIFO.
  output reg read_enable_a_n = 1'b1,
  output reg read_enable_b_n = 1'b1
);
  integer seed = 18946;
  // A stall may drop only one enable, which must not count as a read.
  always @(posedge core_clk) begin
    read_enable_a_n <= !drain || (slow && $random(seed) % 2 != 0);
    read_enable_b_n <= !drain || (slow && $random(seed) % 2 != 0);
  end
endmodule
